/* sim/sd_host_irq_status_tb_top.sv */
`timescale 1ns/1ps
`include "sdirq_defines.vh"
// ==========
// Bench: register tests over the bus with a card model.
module sd_host_irq_status_tb_top;
    logic i_ref_clk = 1'h0, i_reset_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
    logic i_pwrite = 1'h0, i_irq_window = 1'h0, i_crc16_ok = 1'h1, i_crc7_ok = 1'h1;
    logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, o_prdata, r;
    logic o_pready, o_pslverr, o_card_change_irq_en, i_sd_clk, i_dat0, i_dat1, i_dat3, e;
    logic [7:0] ev = 8'h0;
    wire i_data_in_timeout = ev[0], i_resp_timeout = ev[1], i_block_done = ev[2];
    wire i_xfer_abort = ev[3], i_crc7_vld = ev[4], i_crc16_vld = ev[5];
    wire i_token_arm = ev[6], i_prog_error = ev[7];
    int bad_count = 0, tests_run = 0, bits[5] = '{13, 12, 0, 0, 1};
    logic [2:0] toks[2] = '{3'h2, 3'h5};
    localparam logic [31:0] ST = `SDIRQ_ADDR_STATUS;
    always #12.5 i_ref_clk = ~i_ref_clk;
    sdirq_status dut (.*);
    sdirq_card_model card (.o_sd_clk(i_sd_clk), .o_dat0(i_dat0), .o_dat1(i_dat1),
        .o_dat3(i_dat3));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input int k);
        @(posedge i_ref_clk);
        ev <= 8'h0;
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'h1;
        if (k >= 0) ev[k] <= 1'h1;
        do begin
            @(posedge i_ref_clk);
        end while (o_pready !== 1'h1);
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        ev <= 8'h0;
    endtask
    task automatic pulse(input int k, input logic ok);
        @(posedge i_ref_clk);
        ev[k] <= 1'h1;
        i_crc7_ok <= ok;
        i_crc16_ok <= ok;
    endtask
    task automatic settle();
        repeat (8) @(posedge i_ref_clk);
        apb(1'h0, ST, 32'h0, -1);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_reset_n <= 1'h1;
        apb(1'h0, ST, 32'h0, -1);
        chk(r, 32'h0005008C);
        apb(1'h1, `SDIRQ_ADDR_ENABLE, 32'hFFFFFFFF, -1);
        apb(1'h0, `SDIRQ_ADDR_ENABLE, 32'h0, -1);
        chk(r, `SDIRQ_ENABLE_MASK);
        apb(1'h1, `SDIRQ_ADDR_ENABLE, 32'h0, -1);
        for (int i = 0; i < 5; i++) begin
            pulse(i, 1'h0);
            apb(1'h0, ST, 32'h0, -1);
            chk(32'(r[bits[i]]), 32'h1);
            apb(1'h1, ST, 32'h0, -1);
            apb(1'h0, ST, 32'h0, -1);
            chk(32'(r[bits[i]]), 32'h1);
            apb(1'h1, ST, 32'h1 << bits[i], -1);
            apb(1'h0, ST, 32'h0, -1);
            chk(32'(r[bits[i]]), 32'h0);
        end
        chk(32'(r[2]), 32'h0);
        apb(1'h1, ST, 32'h2000, 0);
        apb(1'h0, ST, 32'h0, -1);
        chk(32'(r[13]), 32'h1);
        apb(1'h1, ST, 32'h2000, -1);
        pulse(5, 1'h0);
        apb(1'h0, ST, 32'h0, -1);
        chk(32'(r[3:1]), 32'h1);
        pulse(5, 1'h1);
        apb(1'h0, ST, 32'h0, -1);
        chk(32'(r[3]), 32'h1);
        apb(1'h1, ST, 32'h2, -1);
        card.lines(1'h1, 1'h1, 1'h0);
        settle();
        chk(32'(r[16:8]), 32'h0);
        apb(1'h1, `SDIRQ_ADDR_ENABLE, 32'h100, -1);
        repeat (2) @(posedge i_ref_clk);
        chk(32'(o_card_change_irq_en), 32'h1);
        card.lines(1'h0, 1'h1, 1'h1);
        settle();
        chk(32'(r[16:7]), 32'h202);
        i_irq_window <= 1'h1;
        card.lines(1'h1, 1'h0, 1'h1);
        settle();
        chk(32'(r[18:10]), 32'h41);
        card.lines(1'h1, 1'h1, 1'h1);
        apb(1'h1, ST, 32'h500, -1);
        apb(1'h0, ST, 32'h0, -1);
        chk(32'(r[10] | r[8]), 32'h0);
        for (int i = 0; i < 2; i++) begin
            pulse(6, 1'h1);
            apb(1'h0, 32'hB000D030, 32'h0, -1);
            chk(32'(e), 32'h1);
            card.token(toks[i]);
            settle();
            chk(32'(r[6:4]), 32'(toks[i]));
            chk(32'(r[1]), i);
            apb(1'h1, ST, 32'h2, -1);
        end
        pulse(7, 1'h1);
        apb(1'h0, ST, 32'h0, -1);
        chk(32'(r[6:4]), 32'h7);
        close_out();
    end
endmodule // sd_host_irq_status_tb_top

/* sim/sdirq_card_model.sv */
`timescale 1ns/1ps
// ==========
// Card side: lines idle high by pull-up, clock still outside frames.
module sdirq_card_model (
    output logic o_sd_clk,
    output logic o_dat0,
    output logic o_dat1,
    output logic o_dat3
);
    initial begin
        {o_sd_clk, o_dat0, o_dat1, o_dat3} = 4'h7;
    end
    task automatic lines(input logic d0, input logic d1, input logic d3);
        o_dat0 = d0;
        o_dat1 = d1;
        o_dat3 = d3;
    endtask
    task automatic token(input logic [2:0] t);
        logic [4:0] f;
        f = {1'h0, t, 1'h1};
        for (int i = 4; i >= 0; i--) begin
            o_dat0 = f[i];
            #100 o_sd_clk = 1'h1;
            #100 o_sd_clk = 1'h0;
        end
    endtask
endmodule // sdirq_card_model

/* sim/sdirq_status_sva.sv */
`timescale 1ns/1ps
`include "sdirq_defines.vh"
// ==========
// Port checker for the status register block.
module sdirq_status_sva (
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire o_pready,
    input wire [31:0] o_prdata,
    input wire o_pslverr,
    input wire i_dat1,
    input wire i_dat3,
    input wire i_data_in_timeout,
    input wire i_resp_timeout,
    input wire i_block_done,
    input wire i_crc16_vld,
    input wire i_crc16_ok,
    input wire i_crc7_vld,
    input wire i_crc7_ok,
    input wire o_card_change_irq_en
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    sequence s_rd;
        i_psel && !i_penable && !i_pwrite && i_paddr == `SDIRQ_ADDR_STATUS;
    endsequence
    property p_ready;
        i_psel && !i_penable |=> o_pready ##1 !o_pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not one pulse");
    property p_unmap;
        i_psel && !i_penable && i_paddr != `SDIRQ_ADDR_STATUS
            && i_paddr != `SDIRQ_ADDR_ENABLE |=> o_pslverr && o_prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_di;
        i_data_in_timeout ##1 s_rd |=> o_prdata[13];
    endproperty
    a_di: assert property (p_di) else $error("data timeout not set");
    property p_rsp;
        i_resp_timeout ##1 s_rd |=> o_prdata[12];
    endproperty
    a_rsp: assert property (p_rsp) else $error("response timeout not set");
    property p_done;
        i_block_done ##1 s_rd |=> o_prdata[0];
    endproperty
    a_done: assert property (p_done) else $error("block done not set");
    property p_crc7;
        i_crc7_vld && !i_crc7_ok ##1 s_rd |=> o_prdata[1] && !o_prdata[2];
    endproperty
    a_crc7: assert property (p_crc7) else $error("crc7 fault lost");
    property p_crc16;
        i_crc16_vld ##1 s_rd |=> o_prdata[3] == $past(i_crc16_ok, 2);
    endproperty
    a_crc16: assert property (p_crc16) else $error("crc16 result wrong");
    property p_en;
        i_psel && i_penable && o_pready && i_pwrite && i_paddr == `SDIRQ_ADDR_ENABLE
            |-> ##2 o_card_change_irq_en == $past(i_pwdata[8], 2);
    endproperty
    a_en: assert property (p_en) else $error("change enable wrong");
    property p_pins;
        ($stable({i_dat1, i_dat3}) [*4]) ##0 s_rd
            |=> o_prdata[18] == $past(i_dat1) && o_prdata[16] == $past(i_dat3);
    endproperty
    a_pins: assert property (p_pins) else $error("pin level wrong");
endmodule // sdirq_status_sva

bind sdirq_status sdirq_status_sva u_sva (.*);

/* verilog/sdirq_defines.vh */
`ifndef SDIRQ_DEFINES_VH
`define SDIRQ_DEFINES_VH

// =====================================================================
// Register addresses.
`define SDIRQ_ADDR_ENABLE 32'hB000D028
`define SDIRQ_ADDR_STATUS 32'hB000D02C

// =====================================================================
// Status register field positions.
`define SDIRQ_BIT_LINE1 18
`define SDIRQ_BIT_PRESENCE 16
`define SDIRQ_BIT_DI_TIMEOUT 13
`define SDIRQ_BIT_RSP_TIMEOUT 12
`define SDIRQ_BIT_CARD_IRQ 10
`define SDIRQ_BIT_CARD_CHANGE 8
`define SDIRQ_BIT_LINE0 7
`define SDIRQ_TOKEN_HI 6
`define SDIRQ_TOKEN_LO 4
`define SDIRQ_BIT_CRC16_OK 3
`define SDIRQ_BIT_CRC7_OK 2
`define SDIRQ_BIT_CRC_ERR 1
`define SDIRQ_BIT_BLOCK_DONE 0

// =====================================================================
// Enable register field positions and writable mask.
`define SDIRQ_BIT_CHANGE_EN 8
`define SDIRQ_ENABLE_MASK 32'h40007503

// =====================================================================
// Reset values.
`define SDIRQ_RST_ENABLE 32'h00000000
`define SDIRQ_RST_PIN 1'b1
`define SDIRQ_RST_CRC_OK 1'b1
`define SDIRQ_RST_FLAG 1'b0
`define SDIRQ_RST_TOKEN 3'h0

// =====================================================================
// Write CRC token values and the index of the last token bit.
`define SDIRQ_TOKEN_POS 3'h2
`define SDIRQ_TOKEN_NEG 3'h5
`define SDIRQ_TOKEN_PROG 3'h7
`define SDIRQ_TOKEN_LAST 2'h2

`endif

/* verilog/sdirq_status.v */
`timescale 1ns/1ps
`include "sdirq_defines.vh"
// What this block does
// - Status register at 0xB000_D02C, reset 0x000X_008C with bits 7,3,2 set.
// - Bit 18 mirrors the live line 1 level of port 0.
// - Bit 16 mirrors line 3 of port 0, the card presence sense.
// - Bit 13 sets on data-in start bit time-out; zero otherwise.
// - Bit 12 sets on response start bit time-out, long responses too.
// - Event flags 13,12,10,8 clear by writing one; zero writes keep them.
// - Bit 10 sets when the card signals an interrupt.
// - Bit 8 sets on card insert or remove, only while its enable is one.
// - Bit 7 mirrors the line 0 level of the selected port.
// - Bits 6:4 capture the write CRC token; 010 positive, 101 negative.
// - Token field reads 111 on a card programming error.
// - Bit 3 holds data-in CRC-16 result, bit 2 response CRC-7 result.
// - Bit 1 sets on any CRC error, R3 included; write one clears.
// - Bit 0 sets on block done or aborted multi-block; write one clears.
module sdirq_status (
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg o_pready,
    output reg [31:0] o_prdata,
    output reg o_pslverr,
    input wire i_sd_clk,
    input wire i_dat0,
    input wire i_dat1,
    input wire i_dat3,
    input wire i_data_in_timeout,
    input wire i_resp_timeout,
    input wire i_irq_window,
    input wire i_token_arm,
    input wire i_prog_error,
    input wire i_crc16_vld,
    input wire i_crc16_ok,
    input wire i_crc7_vld,
    input wire i_crc7_ok,
    input wire i_block_done,
    input wire i_xfer_abort,
    output reg o_card_change_irq_en
);

    // =================================================================
    // Token capture states, one-hot.
    localparam ST_IDLE = 3'b001;
    localparam ST_START = 3'b010;
    localparam ST_BITS = 3'b100;

    // =================================================================
    // Pin synchronisers: index 0 line 0, 1 line 1, 2 line 3, 3 clock.
    wire [3:0] pin_raw;
    reg [3:0] meta_q;
    reg [3:0] sync_q;
    reg [3:0] prev_q;

    assign pin_raw = {i_sd_clk, i_dat3, i_dat1, i_dat0};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            always @(posedge i_ref_clk) begin
                if (!i_reset_n) begin
                    meta_q[gi] <= `SDIRQ_RST_PIN;
                    sync_q[gi] <= `SDIRQ_RST_PIN;
                    prev_q[gi] <= `SDIRQ_RST_PIN;
                end else begin
                    meta_q[gi] <= pin_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                    prev_q[gi] <= sync_q[gi];
                end
            end
        end
    endgenerate

    wire line0 = sync_q[0];
    wire line1 = sync_q[1];
    wire line3 = sync_q[2];
    wire sd_rise = sync_q[3] & ~prev_q[3];
    wire line1_fall = prev_q[1] & ~sync_q[1];
    wire line3_edge = prev_q[2] ^ sync_q[2];

    // =================================================================
    // APB slave decode.
    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable & o_pready;
    wire hit_status = (i_paddr == `SDIRQ_ADDR_STATUS);
    wire hit_enable = (i_paddr == `SDIRQ_ADDR_ENABLE);
    wire wr_status = access & i_pwrite & hit_status;
    wire wr_enable = access & i_pwrite & hit_enable;

    // =================================================================
    // Write CRC token capture on the card clock.
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [1:0] cnt_q;
    reg [1:0] cnt_d;
    reg [1:0] shift_q;
    reg [1:0] shift_d;
    reg [2:0] token_q;
    reg [2:0] token_d;
    reg token_done;

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        token_done = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (i_token_arm) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                if (sd_rise && !line0) begin
                    state_d = ST_BITS;
                    cnt_d = 2'h0;
                    shift_d = 2'h0;
                end
            end
            ST_BITS: begin
                if (sd_rise) begin
                    shift_d = {shift_q[0], line0};
                    cnt_d = cnt_q + 2'h1;
                    if (cnt_q == `SDIRQ_TOKEN_LAST) begin
                        token_done = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @* begin
        token_d = token_q;
        if (i_prog_error) begin
            token_d = `SDIRQ_TOKEN_PROG;
        end else if (token_done) begin
            token_d = {shift_q, line0};
        end
    end

    wire token_bad = token_done && ({shift_q, line0} != `SDIRQ_TOKEN_POS);

    // =================================================================
    // Sticky flags: set wins over a write-one clear.
    reg [31:0] enable_q;
    reg [5:0] flag_q;
    wire [5:0] flag_set;
    wire [5:0] flag_clr;
    wire di_to_q = flag_q[0];
    wire rsp_to_q = flag_q[1];
    wire card_irq_q = flag_q[2];
    wire change_q = flag_q[3];
    wire crc_err_q = flag_q[4];
    wire done_q = flag_q[5];
    reg crc16_ok_q;
    reg crc7_ok_q;

    wire set_di_to = i_data_in_timeout;
    wire set_rsp_to = i_resp_timeout;
    wire set_card_irq = i_irq_window & line1_fall;
    wire set_change = line3_edge & enable_q[`SDIRQ_BIT_CHANGE_EN];
    wire crc16_bad = i_crc16_vld & ~i_crc16_ok;
    wire crc7_bad = i_crc7_vld & ~i_crc7_ok;
    wire set_crc_err = crc16_bad | crc7_bad | token_bad;
    wire set_done = i_block_done | i_xfer_abort;

    wire clr_di_to = wr_status & i_pwdata[`SDIRQ_BIT_DI_TIMEOUT];
    wire clr_rsp_to = wr_status & i_pwdata[`SDIRQ_BIT_RSP_TIMEOUT];
    wire clr_card_irq = wr_status & i_pwdata[`SDIRQ_BIT_CARD_IRQ];
    wire clr_change = wr_status & i_pwdata[`SDIRQ_BIT_CARD_CHANGE];
    wire clr_crc_err = wr_status & i_pwdata[`SDIRQ_BIT_CRC_ERR];
    wire clr_done = wr_status & i_pwdata[`SDIRQ_BIT_BLOCK_DONE];

    // =================================================================
    // Flag vectors, one bit per sticky flag cell.
    assign flag_set[0] = set_di_to;
    assign flag_set[1] = set_rsp_to;
    assign flag_set[2] = set_card_irq;
    assign flag_set[3] = set_change;
    assign flag_set[4] = set_crc_err;
    assign flag_set[5] = set_done;
    assign flag_clr[0] = clr_di_to;
    assign flag_clr[1] = clr_rsp_to;
    assign flag_clr[2] = clr_card_irq;
    assign flag_clr[3] = clr_change;
    assign flag_clr[4] = clr_crc_err;
    assign flag_clr[5] = clr_done;

    // =================================================================
    // Sticky flag cells: a set event beats a clear in the same cycle.
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
            always @(posedge i_ref_clk) begin
                if (!i_reset_n) begin
                    flag_q[gi] <= `SDIRQ_RST_FLAG;
                end else begin
                    flag_q[gi] <= flag_set[gi] | (flag_q[gi] & ~flag_clr[gi]);
                end
            end
        end
    endgenerate

    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 2'h0;
            shift_q <= 2'h0;
            token_q <= `SDIRQ_RST_TOKEN;
            enable_q <= `SDIRQ_RST_ENABLE;
            crc16_ok_q <= `SDIRQ_RST_CRC_OK;
            crc7_ok_q <= `SDIRQ_RST_CRC_OK;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            token_q <= token_d;
            if (wr_enable) begin
                enable_q <= i_pwdata & `SDIRQ_ENABLE_MASK;
            end
            if (i_crc16_vld) begin
                crc16_ok_q <= i_crc16_ok;
            end
            if (i_crc7_vld) begin
                crc7_ok_q <= i_crc7_ok;
            end
        end
    end

    // =================================================================
    // Read data assembly.
    reg [31:0] status_word;

    always @* begin
        status_word = 32'h00000000;
        status_word[`SDIRQ_BIT_LINE1] = line1;
        status_word[`SDIRQ_BIT_PRESENCE] = line3;
        status_word[`SDIRQ_BIT_DI_TIMEOUT] = di_to_q;
        status_word[`SDIRQ_BIT_RSP_TIMEOUT] = rsp_to_q;
        status_word[`SDIRQ_BIT_CARD_IRQ] = card_irq_q;
        status_word[`SDIRQ_BIT_CARD_CHANGE] = change_q;
        status_word[`SDIRQ_BIT_LINE0] = line0;
        status_word[`SDIRQ_TOKEN_HI:`SDIRQ_TOKEN_LO] = token_q;
        status_word[`SDIRQ_BIT_CRC16_OK] = crc16_ok_q;
        status_word[`SDIRQ_BIT_CRC7_OK] = crc7_ok_q;
        status_word[`SDIRQ_BIT_CRC_ERR] = crc_err_q;
        status_word[`SDIRQ_BIT_BLOCK_DONE] = done_q;
    end

    // =================================================================
    // Read select: writes and unmapped reads return zero.
    reg [31:0] read_word;

    always @* begin
        read_word = 32'h00000000;
        if (!i_pwrite) begin
            if (hit_status) begin
                read_word = status_word;
            end else if (hit_enable) begin
                read_word = enable_q;
            end
        end
    end

    // =================================================================
    // APB answer: ready one cycle after setup.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_pready <= 1'b0;
            o_card_change_irq_en <= 1'b0;
        end else begin
            o_pready <= setup;
            o_card_change_irq_en <= enable_q[`SDIRQ_BIT_CHANGE_EN];
        end
    end

    // =================================================================
    // Answer data and error, loaded in the setup cycle.
    always @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_pslverr <= ~(hit_status | hit_enable);
            o_prdata <= read_word;
        end else begin
            o_pslverr <= 1'b0;
        end
    end

endmodule // sdirq_status
